// file: verilog/ddr3_pins_pkg.sv
package ddr3_pins_pkg;
  localparam int               DQ_W          = 8;
  localparam int               BA_W          = 3;
  localparam int               ADDR_W        = 13;
  localparam int               BURST_W       = 64;
  localparam int               REF_PERIOD_NS = 20;
  localparam int               CK_PERIOD_NS  = 160;
  localparam int               CK_DIV        = CK_PERIOD_NS / REF_PERIOD_NS;
  localparam int               HALF          = CK_DIV / 2;
  localparam int               QUARTER       = CK_DIV / 4;
  localparam int               CNT_W         = $clog2(CK_DIV);
  localparam int               AP_BIT        = 10;
  localparam int               BC_BIT        = 12;
  localparam int               TERM_STB_BIT  = 11;
  localparam int               RTT_BIT0      = 2;
  localparam int               RTT_BIT1      = 6;
  localparam int               RTT_BIT2      = 9;
  localparam int               MEM_ROW_W     = 2;
  localparam int               MEM_COL_W     = 3;
  localparam logic [1:0]       BL_FIXED8     = 2'h0;
  localparam logic [1:0]       BL_OTF        = 2'h1;
  localparam logic [1:0]       BL_FIXED4     = 2'h2;
  localparam logic [3:0]       BEATS_BL8     = 4'h8;
  localparam logic [3:0]       BEATS_BC4     = 4'h4;
  localparam logic [ADDR_W-1:0] MODE_RESET   = 13'h0000;
  localparam logic             X8_CONFIG     = 1'b1;
  localparam logic [DQ_W-1:0]  DQ_LANES      = X8_CONFIG ? 8'hff : 8'h0f;
  localparam logic [3:0]       PINS_DESEL    = 4'hf;

  typedef enum logic [2:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS, CMD_REF
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
  } power_t;

  // Pins are {cs_n, ras_n, cas_n, we_n}
  function automatic cmd_t decode_cmd(input logic [3:0] pins);
    cmd_t c;
    c = CMD_DESEL;
    if (!pins[3]) begin
      case (pins[2:0])
        3'h3:    c = CMD_ACT;
        3'h5:    c = CMD_RD;
        3'h4:    c = CMD_WR;
        3'h2:    c = CMD_PRE;
        3'h0:    c = CMD_MRS;
        3'h1:    c = CMD_REF;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [3:0] encode_cmd(input cmd_t c);
    logic [3:0] p;
    p = PINS_DESEL;
    unique case (c)
      CMD_DESEL: p = PINS_DESEL;
      CMD_NOP:   p = 4'h7;
      CMD_ACT:   p = 4'h3;
      CMD_RD:    p = 4'h5;
      CMD_WR:    p = 4'h4;
      CMD_PRE:   p = 4'h2;
      CMD_MRS:   p = 4'h0;
      CMD_REF:   p = 4'h1;
    endcase
    return p;
  endfunction

  function automatic logic [3:0] burst_len(input logic [1:0] bl, input logic chop_n);
    logic [3:0] n;
    n = BEATS_BL8;
    if (bl == BL_OTF) begin
      n = chop_n ? BEATS_BL8 : BEATS_BC4;
    end else if (bl == BL_FIXED4) begin
      n = BEATS_BC4;
    end
    return n;
  endfunction
endpackage

// file: verilog/ddr3_link_if.sv
interface ddr3_link_if;
  import ddr3_pins_pkg::*;
  logic              ck;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              termination_control;
  logic              write_mask;
  logic [DQ_W-1:0]   dq_ctl;
  logic              dq_oe_ctl;
  logic [DQ_W-1:0]   dq_dev;
  logic [DQ_W-1:0]   dq_oe_dev;
  logic [DQ_W-1:0]   dq;
  logic              dqs_ctl;
  logic              dqs_oe_ctl;
  logic              dqs_dev;
  logic              dqs_oe_dev;
  logic              dqs;
  logic              dqs_n;
  logic              termination_strobe;
  logic              termination_strobe_n;

  // Undriven wire reads low
  assign dq    = (dq_oe_dev & dq_dev) | ({DQ_W{dq_oe_ctl}} & dq_ctl);
  assign dqs   = (dqs_oe_dev & dqs_dev) | (dqs_oe_ctl & dqs_ctl);
  assign dqs_n = ~dqs;

  modport dev (
    input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_control,
    input  write_mask, dq, dqs,
    output dq_dev, dq_oe_dev, dqs_dev, dqs_oe_dev, termination_strobe,
    output termination_strobe_n
  );

  modport ctl (
    output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_control,
    output write_mask, dq_ctl, dq_oe_ctl, dqs_ctl, dqs_oe_ctl,
    input  dq, dqs
  );
endinterface

// file: verilog/ddr3_device_end.sv
// Overview of operation
// - x8 data bus, shared both directions
// - Device drives strobe edge-aligned on reads
// - Controller drives strobe centred on writes
// - Termination strobe enabled disables write mask
// - Upper nibble, strobe complement only on x8
// - Row on activate, column on access
// - Address bit ten requests auto precharge
// - Precharge one bank or all banks
// - Mode opcode taken from address inputs
// - Address bit twelve chooses burst chop
// - Bank bits pick target bank
// - Bank bits pick mode register zero-three
// - Inputs sampled at rising clock crossing
// - Output strobe timed from clock crossings
// - Clock enable gates internal circuitry
// - Clock enable low enters power-down modes
// - Self refresh exit seen without clock
// - Power-down inputs off except few
// - Chip select high masks every command
// - Chip select part of command encoding
// - Masked write beat not stored
// - Strobes and chip select encode command
// - Termination control ignored when disabled
module ddr3_device_end (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_ce,
  ddr3_link_if.dev                  link,
  output logic [7:0]                o_bank_open,
  output ddr3_pins_pkg::power_t     o_power_state,
  output logic                      o_term_on
);
  import ddr3_pins_pkg::*;

  typedef enum {B_IDLE, B_READ, B_WRITE} burst_t;

  localparam int PIN_W = 6 + BA_W + ADDR_W;

  logic [2:0]          ck_sync_q;
  logic [PIN_W-1:0]    pin_s1_q;
  logic [PIN_W-1:0]    pin_s2_q;
  logic [DQ_W:0]       dat_s1_q;
  logic [DQ_W:0]       dat_s2_q;
  logic [2:0]          dqs_sync_q;
  logic                cke_s;
  logic                term_ctl_s;
  logic [3:0]          cmd_pins;
  logic [BA_W-1:0]     ba_s;
  logic [ADDR_W-1:0]   addr_s;
  logic                mask_s;
  logic [DQ_W-1:0]     dq_s;
  cmd_t                cmd;
  logic                ck_rise;
  logic                ck_edge;
  logic                dqs_edge;
  logic                cmd_ok;
  logic                burst_done;
  logic                term_stb_en;
  logic                rtt_en;
  power_t              pwr_q;
  logic [7:0]          open_q;
  logic [MEM_ROW_W-1:0] row_q [8];
  logic [ADDR_W-1:0]   mode_q [4];
  burst_t              burst_q;
  logic [3:0]          beat_q;
  logic [3:0]          len_q;
  logic [BA_W-1:0]     bank_q;
  logic [MEM_COL_W-1:0] col_q;
  logic                auto_pre_q;
  logic [DQ_W-1:0]     mem_q [256];
  logic [DQ_W-1:0]     dq_out_q;
  logic [DQ_W-1:0]     dq_oe_q;
  logic                dqs_q;
  logic                dqs_oe_q;
  logic                term_q;
  logic                term_stb_q;

  function automatic logic [7:0] mem_idx(input logic [BA_W-1:0] b,
                                         input logic [MEM_ROW_W-1:0] r,
                                         input logic [MEM_COL_W-1:0] c);
    return {b, r, c};
  endfunction

  // Link clock and pins cross in through two stages; clock edges are found
  // on the second and third stage so the first is never looked at
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ck_sync_q  <= 3'h7; // Matches the link clock's reset level, no false rise
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      dat_s1_q   <= '0;
      dat_s2_q   <= '0;
      dqs_sync_q <= 3'h0;
    end else if (i_ce) begin
      ck_sync_q  <= {ck_sync_q[1:0], link.ck};
      pin_s1_q   <= {link.cke, link.termination_control, link.cs_n, link.ras_n,
                     link.cas_n, link.we_n, link.ba, link.addr};
      pin_s2_q   <= pin_s1_q;
      dat_s1_q   <= {link.write_mask, link.dq};
      dat_s2_q   <= dat_s1_q;
      dqs_sync_q <= {dqs_sync_q[1:0], link.dqs};
    end
  end

  assign {cke_s, term_ctl_s, cmd_pins, ba_s, addr_s} = pin_s2_q;
  assign {mask_s, dq_s} = dat_s2_q;
  assign ck_rise  = ck_sync_q[1] & ~ck_sync_q[2];
  assign ck_edge  = ck_sync_q[1] ^ ck_sync_q[2];
  assign dqs_edge = dqs_sync_q[1] ^ dqs_sync_q[2];
  assign cmd      = decode_cmd(cmd_pins);
  // Commands are only heard with the clock on and all buffers awake
  assign cmd_ok   = ck_rise && cke_s && (pwr_q == PWR_ACTIVE)
                    && (burst_q == B_IDLE);
  assign term_stb_en = X8_CONFIG & mode_q[1][TERM_STB_BIT];
  assign rtt_en   = mode_q[1][RTT_BIT0] | mode_q[1][RTT_BIT1] | mode_q[1][RTT_BIT2];
  assign burst_done = ((burst_q == B_READ) && ck_edge && (beat_q == len_q))
                    || ((burst_q == B_WRITE) && dqs_edge && (beat_q == len_q - 4'h1));

  // Power state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pwr_q <= PWR_ACTIVE;
    end else if (i_ce) begin
      unique case (pwr_q)
        PWR_SELF_REF: begin
          // Clock may be stopped here, so the level alone wakes us
          if (cke_s) begin
            pwr_q <= PWR_ACTIVE;
          end
        end
        PWR_PRE_PD, PWR_ACT_PD: begin
          if (ck_rise && cke_s) begin
            pwr_q <= PWR_ACTIVE;
          end
        end
        PWR_ACTIVE: begin
          if (ck_rise && !cke_s && burst_q == B_IDLE) begin
            if (cmd == CMD_REF && open_q == 8'h00) begin
              pwr_q <= PWR_SELF_REF;
            end else if (open_q != 8'h00) begin
              pwr_q <= PWR_ACT_PD;
            end else begin
              pwr_q <= PWR_PRE_PD;
            end
          end
        end
      endcase
    end
  end

  // Bank open state and open row
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      open_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        row_q[i] <= '0;
      end
    end else if (i_ce) begin
      if (cmd_ok && cmd == CMD_ACT) begin
        open_q[ba_s] <= 1'b1;
        row_q[ba_s]  <= addr_s[MEM_ROW_W-1:0];
      end else if (cmd_ok && cmd == CMD_PRE) begin
        if (addr_s[AP_BIT]) begin
          open_q <= 8'h00;
        end else begin
          open_q[ba_s] <= 1'b0;
        end
      end else if (burst_done && auto_pre_q) begin
        open_q[bank_q] <= 1'b0;
      end
    end
  end

  // Mode registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        mode_q[i] <= MODE_RESET;
      end
    end else if (i_ce && cmd_ok && cmd == CMD_MRS && !ba_s[2]) begin
      mode_q[ba_s[1:0]] <= addr_s;
    end
  end

  // Burst sequencing
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      burst_q    <= B_IDLE;
      beat_q     <= 4'h0;
      len_q      <= BEATS_BL8;
      bank_q     <= '0;
      col_q      <= '0;
      auto_pre_q <= 1'b0;
    end else if (i_ce) begin
      if (cmd_ok && (cmd == CMD_RD || cmd == CMD_WR)) begin
        burst_q    <= (cmd == CMD_RD) ? B_READ : B_WRITE;
        beat_q     <= 4'h0;
        len_q      <= burst_len(mode_q[0][1:0], addr_s[BC_BIT]);
        bank_q     <= ba_s;
        col_q      <= addr_s[MEM_COL_W-1:0];
        auto_pre_q <= addr_s[AP_BIT];
      end else if (burst_done) begin
        burst_q <= B_IDLE;
      end else if ((burst_q == B_READ && ck_edge) || (burst_q == B_WRITE && dqs_edge)) begin
        beat_q <= beat_q + 4'h1;
      end
    end
  end

  // Read drive: byte and strobe change on the same clock edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      dq_out_q <= '0;
      dq_oe_q  <= '0;
      dqs_q    <= 1'b0;
      dqs_oe_q <= 1'b0;
    end else if (i_ce && burst_q == B_READ && ck_edge) begin
      if (beat_q != len_q) begin
        dq_out_q <= mem_q[mem_idx(bank_q, row_q[bank_q],
                                  col_q + beat_q[MEM_COL_W-1:0])];
        dq_oe_q  <= DQ_LANES;
        dqs_oe_q <= 1'b1;
        dqs_q    <= ~dqs_q;
      end else begin
        dq_oe_q  <= '0;
        dqs_oe_q <= 1'b0;
        dqs_q    <= 1'b0;
      end
    end
  end

  // Write capture on each strobe edge unless the beat is masked; strobe sits mid-eye so data is settled
  always_ff @(posedge i_ref_clk) begin
    if (i_ce && burst_q == B_WRITE && dqs_edge && !(mask_s && !term_stb_en)) begin
      mem_q[mem_idx(bank_q, row_q[bank_q], col_q + beat_q[MEM_COL_W-1:0])] <= dq_s & DQ_LANES;
    end
  end

  // Termination follows control only when enabled and out of self refresh
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      term_q     <= 1'b0;
      term_stb_q <= 1'b0;
    end else if (i_ce) begin
      if (pwr_q == PWR_SELF_REF) begin
        term_q <= 1'b0;
      end else if (ck_rise) begin
        term_q <= term_ctl_s & rtt_en;
      end
      term_stb_q <= term_q & term_stb_en;
    end
  end

  assign link.dq_dev               = dq_out_q;
  assign link.dq_oe_dev            = dq_oe_q;
  assign link.dqs_dev              = dqs_q;
  assign link.dqs_oe_dev           = dqs_oe_q;
  assign link.termination_strobe   = term_stb_q;
  assign link.termination_strobe_n = term_stb_q;
  assign o_bank_open               = open_q;
  assign o_power_state             = pwr_q;
  assign o_term_on                 = term_q;
endmodule

// file: verilog/ddr3_controller_end.sv
module ddr3_controller_end (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_ce,
  ddr3_link_if.ctl                           link,
  input  wire logic                          i_cmd_valid,
  input  ddr3_pins_pkg::cmd_t                i_cmd,
  input  wire logic [ddr3_pins_pkg::BA_W-1:0]    i_bank,
  input  wire logic [ddr3_pins_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [ddr3_pins_pkg::BURST_W-1:0] i_wdata,
  input  wire logic [7:0]                    i_wmask,
  input  wire logic                          i_cke,
  input  wire logic                          i_term_ctl,
  output logic                               o_cmd_ready,
  output logic                               o_rd_valid,
  output logic [ddr3_pins_pkg::BURST_W-1:0]  o_rd_data,
  input  wire logic                          i_rd_ready
);
  import ddr3_pins_pkg::*;

  typedef enum {C_IDLE, C_READ, C_WRITE} cstate_t;

  logic [CNT_W-1:0]   cnt_q;
  logic               ck_q;
  logic               slot;
  logic               edge_now;
  logic               tog_now;
  logic               take;
  logic               ready_q;
  cstate_t            st_q;
  logic [3:0]         pins_q;
  logic [BA_W-1:0]    ba_q;
  logic [ADDR_W-1:0]  addr_q;
  logic               cke_q;
  logic               term_q;
  logic [1:0]         mode_bl_q;
  logic [3:0]         len_q;
  logic [3:0]         beat_q;
  logic               started_q;
  logic               pend_q;
  logic [BURST_W-1:0] wdata_q;
  logic [7:0]         wmask_q;
  logic [DQ_W-1:0]    dq_q;
  logic               dq_oe_q;
  logic               mask_q;
  logic               dqs_q;
  logic               dqs_oe_q;
  logic [DQ_W-1:0]    dq_s1_q;
  logic [DQ_W-1:0]    dq_s2_q;
  logic [2:0]         dqs_sync_q;
  logic               dqs_edge;
  logic [BURST_W-1:0] word_q;
  logic [BURST_W-1:0] word_full;
  logic               push;
  logic               pop;
  logic [BURST_W-1:0] head_q;
  logic               head_v_q;
  logic [BURST_W-1:0] tail_q;
  logic               tail_v_q;

  assign slot     = cnt_q == CNT_W'(HALF - 1);
  assign edge_now = slot || (cnt_q == CNT_W'(CK_DIV - 1));
  assign tog_now  = (cnt_q == CNT_W'(QUARTER - 1)) || (cnt_q == CNT_W'(HALF + QUARTER - 1));
  assign take     = slot && ready_q && i_cmd_valid;
  assign dqs_edge = dqs_sync_q[1] ^ dqs_sync_q[2];
  assign push     = st_q == C_READ && dqs_edge && beat_q == len_q - 4'h1;
  assign pop      = head_v_q && i_rd_ready;

  // Last beat merged on the fly so the word is whole on push
  always_comb begin
    word_full = word_q;
    word_full[DQ_W*beat_q[2:0] +: DQ_W] = dq_s2_q;
  end

  // Link clock divided from the reference; commands change on its fall
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      // Idles high so the first command change lands on a clock fall
      ck_q  <= 1'b1;
    end else if (i_ce) begin
      cnt_q <= (cnt_q == CNT_W'(CK_DIV - 1)) ? '0 : cnt_q + CNT_W'(1);
      if (cnt_q == CNT_W'(CK_DIV - 1)) begin
        ck_q <= 1'b1;
      end else if (slot) begin
        ck_q <= 1'b0;
      end
    end
  end

  // Ready only when a read could still land in the buffer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ready_q <= 1'b0;
    end else if (i_ce) begin
      ready_q <= (cnt_q == CNT_W'(HALF - 2)) && st_q == C_IDLE && !tail_v_q;
    end
  end

  // Command pins
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pins_q    <= PINS_DESEL;
      ba_q      <= '0;
      addr_q    <= '0;
      cke_q     <= 1'b0;
      term_q    <= 1'b0;
      mode_bl_q <= BL_FIXED8;
    end else if (i_ce && slot) begin
      pins_q <= take ? encode_cmd(i_cmd) : PINS_DESEL;
      cke_q  <= i_cke;
      term_q <= i_term_ctl;
      if (take) begin
        ba_q   <= i_bank;
        addr_q <= i_addr;
        if (i_cmd == CMD_MRS && i_bank == BA_W'(0)) begin
          mode_bl_q <= i_addr[1:0];
        end
      end
    end
  end

  // Read data crosses in through two stages
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      dq_s1_q    <= '0;
      dq_s2_q    <= '0;
      dqs_sync_q <= 3'h0;
    end else if (i_ce) begin
      dq_s1_q    <= link.dq;
      dq_s2_q    <= dq_s1_q;
      dqs_sync_q <= {dqs_sync_q[1:0], link.dqs};
    end
  end

  // Transfer sequencing
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q      <= C_IDLE;
      len_q     <= BEATS_BL8;
      beat_q    <= 4'h0;
      started_q <= 1'b0;
      pend_q    <= 1'b0;
      wdata_q   <= '0;
      wmask_q   <= 8'h00;
      word_q    <= '0;
      dq_q      <= '0;
      dq_oe_q   <= 1'b0;
      mask_q    <= 1'b0;
      dqs_q     <= 1'b0;
      dqs_oe_q  <= 1'b0;
    end else if (i_ce) begin
      if (take && (i_cmd == CMD_RD || i_cmd == CMD_WR)) begin
        st_q      <= (i_cmd == CMD_RD) ? C_READ : C_WRITE;
        len_q     <= burst_len(mode_bl_q, i_addr[BC_BIT]);
        beat_q    <= 4'h0;
        started_q <= 1'b0;
        wdata_q   <= i_wdata;
        wmask_q   <= i_wmask;
        word_q    <= '0;
      end else if (st_q == C_WRITE && edge_now) begin
        if (!started_q) begin
          started_q <= 1'b1;
        end else if (beat_q != len_q) begin
          dq_q     <= wdata_q[DQ_W*beat_q +: DQ_W];
          mask_q   <= wmask_q[beat_q[2:0]];
          dq_oe_q  <= 1'b1;
          dqs_oe_q <= 1'b1;
          pend_q   <= 1'b1;
          beat_q   <= beat_q + 4'h1;
        end else begin
          dq_oe_q  <= 1'b0;
          dqs_oe_q <= 1'b0;
          dqs_q    <= 1'b0;
          mask_q   <= 1'b0;
          st_q     <= C_IDLE;
        end
      end else if (st_q == C_WRITE && tog_now && pend_q) begin
        // Quarter period after the data change puts the edge mid-eye
        dqs_q  <= ~dqs_q;
        pend_q <= 1'b0;
      end else if (st_q == C_READ && dqs_edge) begin
        word_q[DQ_W*beat_q +: DQ_W] <= dq_s2_q;
        beat_q <= beat_q + 4'h1;
        if (push) begin
          st_q <= C_IDLE;
        end
      end
    end
  end

  // Two-entry read buffer; the full word goes in on the last beat
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      head_q   <= '0;
      head_v_q <= 1'b0;
      tail_q   <= '0;
      tail_v_q <= 1'b0;
    end else if (i_ce) begin
      unique case ({push, pop})
        2'h1: begin
          head_q   <= tail_q;
          head_v_q <= tail_v_q;
          tail_v_q <= 1'b0;
        end
        2'h2: begin
          if (!head_v_q) begin
            head_q   <= word_full;
            head_v_q <= 1'b1;
          end else begin
            tail_q   <= word_full;
            tail_v_q <= 1'b1;
          end
        end
        2'h3: begin
          if (tail_v_q) begin
            head_q <= tail_q;
            tail_q <= word_full;
          end else begin
            head_q <= word_full;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign link.ck                  = ck_q;
  assign link.cke                 = cke_q;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins_q;
  assign link.ba                  = ba_q;
  assign link.addr                = addr_q;
  assign link.termination_control = term_q;
  assign link.write_mask          = mask_q;
  assign link.dq_ctl              = dq_q;
  assign link.dq_oe_ctl           = dq_oe_q;
  assign link.dqs_ctl             = dqs_q;
  assign link.dqs_oe_ctl          = dqs_oe_q;
  assign o_cmd_ready              = ready_q;
  assign o_rd_valid               = head_v_q;
  assign o_rd_data                = head_q;
endmodule

// file: dv/ddr3_link_assertions.sv
module ddr3_link_assertions (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       ck,
  input wire logic       cke,
  input wire logic       cs_n,
  input wire logic       dq_oe_ctl,
  input wire logic [7:0] dq_oe_dev,
  input wire logic       dqs_oe_ctl,
  input wire logic       dqs_oe_dev,
  input wire logic       termination_strobe,
  input wire logic       termination_strobe_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  one_driver_a: assert property (!(dq_oe_ctl && (|dq_oe_dev)))
    else $error("data bus fight");
  rd_strobe_a: assert property (dqs_oe_dev |-> dq_oe_dev == 8'hff)
    else $error("read strobe lanes");
  wr_strobe_a: assert property (dq_oe_ctl |-> dqs_oe_ctl)
    else $error("write strobe off");
  tstb_pair_a: assert property (termination_strobe == termination_strobe_n)
    else $error("strobe pair split");
  cmd_on_fall_a: assert property ($changed(cs_n) |-> $fell(ck))
    else $error("select off edge");
  cmd_stands_a: assert property ($fell(cs_n) |=> !cs_n [*7])
    else $error("command short");
  ck_high_a: assert property ($rose(ck) |=> ck [*3] ##1 !ck)
    else $error("link clock shape");
  cke_on_fall_a: assert property ($changed(cke) |-> $fell(ck))
    else $error("enable off edge");

  cover property (dqs_oe_dev);
  cover property (dqs_oe_ctl);
  cover property ($fell(cke));
endmodule

// file: dv/ddr3_sdram_pin_command_interface_bench.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module ddr3_sdram_pin_command_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr3_pins_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, cke = 1'b1, term = 1'b0, rdy = 1'b1;
  logic        ready, rvld, term_on;
  cmd_t        cmd = CMD_NOP;
  logic [2:0]  bank = 3'h0;
  logic [12:0] addr = 13'h0000;
  logic [63:0] wd = 64'h0000_0000_0000_0000, rd;
  logic [63:0] dat = 64'h0123_4567_89ab_cdef;
  logic [7:0]  wm = 8'h00, bopen;
  power_t      pwr;
  int          err_total = 0, cmp_count = 0;

  always #10 clk = ~clk;
  ddr3_link_if link ();
  ddr3_controller_end i_ddr3_controller_end (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .link(link), .i_cmd_valid(vld), .i_cmd(cmd), .i_bank(bank), .i_addr(addr), .i_wdata(wd),
    .i_wmask(wm), .i_cke(cke), .i_term_ctl(term), .o_cmd_ready(ready), .o_rd_valid(rvld),
    .o_rd_data(rd), .i_rd_ready(rdy));
  ddr3_device_end i_ddr3_device_end (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .link(link), .o_bank_open(bopen), .o_power_state(pwr), .o_term_on(term_on));
  ddr3_link_assertions i_ddr3_link_assertions (.i_ref_clk(clk), .i_rst_n(rst_n), .ck(link.ck),
    .cke(link.cke), .cs_n(link.cs_n), .dq_oe_ctl(link.dq_oe_ctl), .dq_oe_dev(link.dq_oe_dev),
    .dqs_oe_ctl(link.dqs_oe_ctl), .dqs_oe_dev(link.dqs_oe_dev),
    .termination_strobe(link.termination_strobe),
    .termination_strobe_n(link.termination_strobe_n));

  task automatic report_and_stop;
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic settle;
    repeat (40) @(posedge clk);
  endtask

  // Enable rides with the command so both reach the same link clock rise
  task automatic send(input cmd_t c, input logic [2:0] b, input logic [12:0] a,
      input logic [63:0] d = 64'h0000_0000_0000_0000, input logic [7:0] m = 8'h00,
      input logic k = 1'b1);
    int n;
    @(posedge clk);
    cmd <= c;
    bank <= b;
    addr <= a;
    wd <= d;
    wm <= m;
    cke <= k;
    vld <= 1'b1;
    n = 0;
    // Ready is looked at mid-cycle; the next rise is the taking edge
    do begin
      @(negedge clk);
      n++;
    end while (ready !== 1'b1 && n < 200);
    `CHK(n < 200, 1'b1)
    @(posedge clk);
    vld <= 1'b0;
  endtask

  task automatic get(input logic [63:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(rvld === 1'b1 && rdy === 1'b1) && n < 300);
    `CHK(n < 300, 1'b1)
    `CHK(rd, exp)
    @(posedge clk);
  endtask

  task automatic t_rw;
    send(CMD_ACT, 3'h1, 13'h0001);
    send(CMD_ACT, 3'h2, 13'h0000);
    send(CMD_WR, 3'h1, 13'h0000, 64'h1111_2222_3333_4444);
    send(CMD_WR, 3'h1, 13'h0000, 64'h5555_6666_7777_8888, 8'h04);
    send(CMD_WR, 3'h2, 13'h0000, dat);
    settle;
    `CHK(bopen, 8'h06)
    rdy <= 1'b0;
    send(CMD_RD, 3'h1, 13'h0000);
    send(CMD_RD, 3'h2, 13'h0400);
    settle;
    `CHK(rvld, 1'b1)
    rdy <= 1'b1;
    get(64'h5555_6666_7733_8888);
    get(dat);
    settle;
    `CHK(bopen, 8'h02)
  endtask

  task automatic t_pre;
    send(CMD_ACT, 3'h3, 13'h0000);
    send(CMD_PRE, 3'h1, 13'h0000);
    settle;
    `CHK(bopen, 8'h08)
    send(CMD_ACT, 3'h5, 13'h0000);
    send(CMD_PRE, 3'h0, 13'h0400);
    settle;
    `CHK(bopen, 8'h00)
  endtask

  task automatic t_chop;
    send(CMD_MRS, 3'h0, 13'h0001);
    send(CMD_ACT, 3'h4, 13'h0000);
    send(CMD_WR, 3'h4, 13'h1000, 64'hfedc_ba98_7654_3210);
    send(CMD_WR, 3'h4, 13'h0000, dat);
    send(CMD_RD, 3'h4, 13'h1000);
    get(64'hfedc_ba98_89ab_cdef);
    send(CMD_RD, 3'h4, 13'h0000);
    get(64'h0000_0000_89ab_cdef);
    send(CMD_MRS, 3'h0, 13'h0000);
  endtask

  task automatic t_term;
    term <= 1'b1;
    settle;
    `CHK(term_on, 1'b0)
    send(CMD_MRS, 3'h1, 13'h0804);
    settle;
    `CHK(term_on, 1'b1)
    `CHK(link.termination_strobe, 1'b1)
    send(CMD_ACT, 3'h6, 13'h0000);
    send(CMD_WR, 3'h6, 13'h0000, dat, 8'hff);
    send(CMD_RD, 3'h6, 13'h0000);
    get(dat);
    send(CMD_MRS, 3'h1, 13'h0000);
    settle;
    `CHK(term_on, 1'b0)
  endtask

  task automatic t_pwr;
    cke <= 1'b0;
    settle;
    `CHK(pwr, PWR_ACT_PD)
    cke <= 1'b1;
    settle;
    `CHK(pwr, PWR_ACTIVE)
    send(CMD_PRE, 3'h0, 13'h0400);
    cke <= 1'b0;
    settle;
    `CHK(pwr, PWR_PRE_PD)
    cke <= 1'b1;
    settle;
    send(CMD_REF, 3'h0, 13'h0000, , , 1'b0);
    settle;
    `CHK(pwr, PWR_SELF_REF)
    cke <= 1'b1;
    settle;
    `CHK(pwr, PWR_ACTIVE)
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(bopen, 8'h00)
    t_rw;
    t_pre;
    t_chop;
    t_term;
    t_pwr;
    report_and_stop;
  end

  // Whole sequence needs roughly a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
endmodule
